// ---- design/umh_pkg.sv ----
// Shared constants and types of the two-port modem handshake block
package umh_pkg;

  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam int NUM_PORTS = 2;
  localparam int NUM_LINES = 4;
  localparam int MSTAT_W = 2 * NUM_LINES;
  localparam int MCTL_W = 5;
  localparam int IER_W = 4;
  localparam int PORT_BIT = 4;

  // Byte addresses of the register map
  localparam logic [AXI_AW-1:0] OFF_MCTL = 8'h00;
  localparam logic [AXI_AW-1:0] OFF_MSTAT = 8'h04;
  localparam logic [AXI_AW-1:0] OFF_IER = 8'h08;
  localparam logic [AXI_AW-1:0] PORT_STRIDE = 8'h10;
  localparam logic [AXI_AW-1:0] PORT_AREA_END = 8'h20;
  localparam logic [AXI_AW-1:0] OFF_ISTAT = 8'h20;
  localparam logic [AXI_AW-1:0] OFF_IEN = 8'h24;
  localparam logic [AXI_AW-1:0] OFF_ICLR = 8'h28;

  // Field positions
  localparam int MCTL_TERM_BIT = 0;
  localparam int MCTL_REQ_BIT = 1;
  localparam int MCTL_LOOP_BIT = 4;
  localparam int IER_MODEM_BIT = 3;

  // Reset values
  localparam logic [MCTL_W-1:0] MCTL_RST = 5'h00;
  localparam logic [IER_W-1:0] IER_RST = 4'h0;
  localparam logic [NUM_PORTS-1:0] IRQ_RST = 2'h0;
  localparam logic [NUM_LINES-1:0] PINS_IDLE = 4'hf;
  localparam logic [MSTAT_W-1:0] MSTAT_RST = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_MCTL, SEL_MSTAT, SEL_IER, SEL_ISTAT, SEL_IEN, SEL_ICLR
  } umh_sel_t;

endpackage : umh_pkg

// ---- design/umh_port_sync.sv ----
// One port's input synchroniser, change detector and modem status byte
`timescale 1ns/1ps
`default_nettype none
module umh_port_sync
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [umh_pkg::NUM_LINES-1:0] i_pins_n,
  input wire logic i_mstat_rd,
  output logic [umh_pkg::MSTAT_W-1:0] o_mstat,
  output logic o_change
);
  import umh_pkg::*;

  logic [NUM_LINES-1:0] s1_reg;
  logic [NUM_LINES-1:0] s2_reg;
  logic [NUM_LINES-1:0] s3_reg;
  logic [NUM_LINES-1:0] filt_reg;
  logic [NUM_LINES-1:0] filt_next;
  logic [NUM_LINES-1:0] rise;
  logic [NUM_LINES-1:0] delta_next;
  logic [MSTAT_W-1:0] mstat_next;
  logic change_next;

  always_comb
  begin
    // A line moves only once the second and third stages agree
    filt_next = (s3_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));
    rise = ~filt_reg & filt_next;
    // A rising pin in the read cycle still sets its flag
    delta_next = (o_mstat[NUM_LINES-1:0] & ~{NUM_LINES{i_mstat_rd}}) | rise;
    mstat_next = {~filt_next, delta_next};
    change_next = |(filt_reg ^ filt_next);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      s1_reg <= PINS_IDLE;
      s2_reg <= PINS_IDLE;
      s3_reg <= PINS_IDLE;
      filt_reg <= PINS_IDLE;
      o_mstat <= MSTAT_RST;
      o_change <= 1'b0;
    end
    else
    begin
      s1_reg <= i_pins_n;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next;
      o_mstat <= mstat_next;
      o_change <= change_next;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  mstat_level_a: assert property ((s2_reg == s3_reg) |=>
    (o_mstat[MSTAT_W-1:NUM_LINES] == ~$past(s3_reg)))
    else $error("status level bits do not follow the settled pins");

  delta_set_a: assert property ((rise != '0) |=>
    ((o_mstat[NUM_LINES-1:0] & $past(rise)) == $past(rise)))
    else $error("rising pin did not set its change flag");

  read_clear_a: assert property ((i_mstat_rd && rise == '0) |=>
    (o_mstat[NUM_LINES-1:0] == '0))
    else $error("status read did not clear the change flags");

endmodule : umh_port_sync
`default_nettype wire

// ---- design/umh_modem_hs.sv ----
// Two-port modem handshake block with an AXI4-Lite register slave
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module umh_modem_hs
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [umh_pkg::AXI_AW-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [umh_pkg::AXI_DW-1:0] i_s_axi_wdata,
  input wire logic [umh_pkg::AXI_DW/8-1:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [umh_pkg::AXI_AW-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [umh_pkg::AXI_DW-1:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic i_clear_send_n_port1,
  input wire logic i_set_ready_n_port1,
  input wire logic i_ring_ind_n_port1,
  input wire logic i_carrier_det_n_port1,
  input wire logic i_clear_send_n_port2,
  input wire logic i_set_ready_n_port2,
  input wire logic i_ring_ind_n_port2,
  input wire logic i_carrier_det_n_port2,
  output logic o_term_ready_n_port1,
  output logic o_term_ready_n_port2,
  output logic o_req_send_n_port1,
  output logic o_req_send_n_port2,
  output logic o_irq_port1,
  output logic o_irq_port2,
  output logic o_irq
);
  import umh_pkg::*;

  // Register select from a byte address
  function automatic umh_sel_t decode_sel(input logic [AXI_AW-1:0] a);
    logic [AXI_AW-1:0] off;
    off = a & ~PORT_STRIDE;
    if (a == OFF_ISTAT)
      return SEL_ISTAT;
    if (a == OFF_IEN)
      return SEL_IEN;
    if (a == OFF_ICLR)
      return SEL_ICLR;
    if (a >= PORT_AREA_END)
      return SEL_NONE;
    if (off == OFF_MCTL)
      return SEL_MCTL;
    if (off == OFF_MSTAT)
      return SEL_MSTAT;
    if (off == OFF_IER)
      return SEL_IER;
    return SEL_NONE;
  endfunction : decode_sel

  function automatic logic port_of(input logic [AXI_AW-1:0] a);
    return a[PORT_BIT];
  endfunction : port_of

  // Bus slave state
  logic aw_held_reg;
  logic aw_held_next;
  logic [AXI_AW-1:0] awaddr_reg;
  logic [AXI_AW-1:0] awaddr_next;
  logic w_held_reg;
  logic w_held_next;
  logic [AXI_DW-1:0] wdata_reg;
  logic [AXI_DW-1:0] wdata_next;
  logic wstrb0_reg;
  logic wstrb0_next;
  logic awready_next;
  logic wready_next;
  logic bvalid_next;
  logic [1:0] bresp_next;
  logic arready_next;
  logic rvalid_next;
  logic [AXI_DW-1:0] rdata_next;
  logic [1:0] rresp_next;
  logic do_wr;
  logic ar_fire;
  umh_sel_t wsel;
  umh_sel_t rsel;

  // Register file state
  logic [NUM_PORTS-1:0][MCTL_W-1:0] mctl_reg;
  logic [NUM_PORTS-1:0][MCTL_W-1:0] mctl_next;
  logic [NUM_PORTS-1:0][IER_W-1:0] ier_reg;
  logic [NUM_PORTS-1:0][IER_W-1:0] ier_next;
  logic [NUM_PORTS-1:0] istat_reg;
  logic [NUM_PORTS-1:0] istat_next;
  logic [NUM_PORTS-1:0] ien_reg;
  logic [NUM_PORTS-1:0] ien_next;
  logic [NUM_PORTS-1:0] clr;
  logic [NUM_PORTS-1:0] mstat_rd;
  logic [NUM_PORTS-1:0] term_n_reg;
  logic [NUM_PORTS-1:0] term_n_next;
  logic [NUM_PORTS-1:0] rts_n_reg;
  logic [NUM_PORTS-1:0] rts_n_next;
  logic irq_next;

  // Per-port status from the synchronisers
  logic [NUM_PORTS-1:0][NUM_LINES-1:0] pins_n;
  logic [NUM_PORTS-1:0][MSTAT_W-1:0] mstat;
  logic [NUM_PORTS-1:0] chg;

  assign pins_n[0] = {i_carrier_det_n_port1, i_ring_ind_n_port1,
                      i_set_ready_n_port1, i_clear_send_n_port1};
  assign pins_n[1] = {i_carrier_det_n_port2, i_ring_ind_n_port2,
                      i_set_ready_n_port2, i_clear_send_n_port2};

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : g_port
      umh_port_sync u_sync
      (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_pins_n(pins_n[p]),
        .i_mstat_rd(mstat_rd[p]),
        .o_mstat(mstat[p]),
        .o_change(chg[p])
      );
    end
  endgenerate

  assign do_wr = aw_held_reg && w_held_reg && !o_s_axi_bvalid;
  assign ar_fire = i_s_axi_arvalid && o_s_axi_arready;
  assign wsel = decode_sel(awaddr_reg);
  assign rsel = decode_sel(i_s_axi_araddr);

  // Bus slave: address and data taken in either order, one of each held
  always_comb
  begin
    aw_held_next = aw_held_reg;
    awaddr_next = awaddr_reg;
    w_held_next = w_held_reg;
    wdata_next = wdata_reg;
    wstrb0_next = wstrb0_reg;
    bvalid_next = o_s_axi_bvalid;
    bresp_next = o_s_axi_bresp;
    rvalid_next = o_s_axi_rvalid;
    rdata_next = o_s_axi_rdata;
    rresp_next = o_s_axi_rresp;
    mstat_rd = '0;
    if (i_s_axi_awvalid && o_s_axi_awready)
    begin
      aw_held_next = 1'b1;
      awaddr_next = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && o_s_axi_wready)
    begin
      w_held_next = 1'b1;
      wdata_next = i_s_axi_wdata;
      wstrb0_next = i_s_axi_wstrb[0];
    end
    if (o_s_axi_bvalid && i_s_axi_bready)
      bvalid_next = 1'b0;
    if (do_wr)
    begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    if (o_s_axi_rvalid && i_s_axi_rready)
      rvalid_next = 1'b0;
    if (ar_fire)
    begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      case (rsel)
        SEL_MCTL: rdata_next = AXI_DW'(mctl_reg[port_of(i_s_axi_araddr)]);
        SEL_MSTAT:
        begin
          rdata_next = AXI_DW'(mstat[port_of(i_s_axi_araddr)]);
          mstat_rd[port_of(i_s_axi_araddr)] = 1'b1;
        end
        SEL_IER: rdata_next = AXI_DW'(ier_reg[port_of(i_s_axi_araddr)]);
        SEL_ISTAT: rdata_next = AXI_DW'(istat_reg);
        SEL_IEN: rdata_next = AXI_DW'(ien_reg);
        SEL_ICLR: rdata_next = '0;
        default:
        begin
          rdata_next = '0;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
    awready_next = !aw_held_next && !bvalid_next;
    wready_next = !w_held_next && !bvalid_next;
    arready_next = !rvalid_next;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= '0;
      w_held_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb0_reg <= 1'b0;
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready <= 1'b0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= RESP_OKAY;
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= '0;
      o_s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      aw_held_reg <= aw_held_next;
      awaddr_reg <= awaddr_next;
      w_held_reg <= w_held_next;
      wdata_reg <= wdata_next;
      wstrb0_reg <= wstrb0_next;
      o_s_axi_awready <= awready_next;
      o_s_axi_wready <= wready_next;
      o_s_axi_bvalid <= bvalid_next;
      o_s_axi_bresp <= bresp_next;
      o_s_axi_arready <= arready_next;
      o_s_axi_rvalid <= rvalid_next;
      o_s_axi_rdata <= rdata_next;
      o_s_axi_rresp <= rresp_next;
    end
  end

  // Register file, handshake outputs and interrupt status
  always_comb
  begin
    mctl_next = mctl_reg;
    ier_next = ier_reg;
    ien_next = ien_reg;
    clr = '0;
    if (do_wr && wstrb0_reg)
    begin
      case (wsel)
        SEL_MCTL: mctl_next[port_of(awaddr_reg)] = wdata_reg[MCTL_W-1:0];
        SEL_IER: ier_next[port_of(awaddr_reg)] = wdata_reg[IER_W-1:0];
        SEL_IEN: ien_next = wdata_reg[NUM_PORTS-1:0];
        SEL_ICLR: clr = wdata_reg[NUM_PORTS-1:0];
        default: clr = '0;
      endcase
    end
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      // Loopback forces both modem outputs inactive
      term_n_next[i] = !mctl_next[i][MCTL_TERM_BIT] || mctl_next[i][MCTL_LOOP_BIT];
      rts_n_next[i] = !mctl_next[i][MCTL_REQ_BIT] || mctl_next[i][MCTL_LOOP_BIT];
      // A change in the clearing cycle keeps the bit set
      istat_next[i] = (istat_reg[i] && !clr[i])
                    || (chg[i] && ier_reg[i][IER_MODEM_BIT]);
    end
    irq_next = |(istat_next & ien_next);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      mctl_reg <= {NUM_PORTS{MCTL_RST}};
      ier_reg <= {NUM_PORTS{IER_RST}};
      ien_reg <= IRQ_RST;
      istat_reg <= IRQ_RST;
      term_n_reg <= '1;
      rts_n_reg <= '1;
      o_irq <= 1'b0;
    end
    else
    begin
      mctl_reg <= mctl_next;
      ier_reg <= ier_next;
      ien_reg <= ien_next;
      istat_reg <= istat_next;
      term_n_reg <= term_n_next;
      rts_n_reg <= rts_n_next;
      o_irq <= irq_next;
    end
  end

  assign o_term_ready_n_port1 = term_n_reg[0];
  assign o_term_ready_n_port2 = term_n_reg[1];
  assign o_req_send_n_port1 = rts_n_reg[0];
  assign o_req_send_n_port2 = rts_n_reg[1];
  assign o_irq_port1 = istat_reg[0];
  assign o_irq_port2 = istat_reg[1];

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  sequence aw_taken;
    i_s_axi_awvalid && o_s_axi_awready;
  endsequence

  sequence w_taken;
    i_s_axi_wvalid && o_s_axi_wready;
  endsequence

  sequence ar_taken;
    i_s_axi_arvalid && o_s_axi_arready;
  endsequence

  reset_idle_a: assert property ($fell(i_sys_rst) |->
    (term_n_reg == '1 && rts_n_reg == '1))
    else $error("modem outputs not inactive after reset");

  wr_answer_a: assert property ((aw_taken and w_taken) |=> ##1 o_s_axi_bvalid)
    else $error("write response missing two cycles after handshake");

  rd_answer_a: assert property (ar_taken |=> o_s_axi_rvalid)
    else $error("read data missing one cycle after address");

  irq_raise_a: assert property ((|(chg & ien_next & ier_mod_bits())) |=> o_irq)
    else $error("enabled modem change did not raise the interrupt");

  function automatic logic [NUM_PORTS-1:0] ier_mod_bits();
    logic [NUM_PORTS-1:0] b;
    for (int i = 0; i < NUM_PORTS; i++)
      b[i] = ier_reg[i][IER_MODEM_BIT];
    return b;
  endfunction : ier_mod_bits

  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : g_chk
      term_drive_a: assert property (!mctl_reg[p][MCTL_LOOP_BIT] |=>
        (term_n_reg[p] == !$past(mctl_reg[p][MCTL_TERM_BIT]) || $past(do_wr)))
        else $error("terminal-ready pin does not follow control bit 0");

      rts_drive_a: assert property (!mctl_reg[p][MCTL_LOOP_BIT] |=>
        (rts_n_reg[p] == !$past(mctl_reg[p][MCTL_REQ_BIT]) || $past(do_wr)))
        else $error("request-to-send pin does not follow control bit 1");

      loop_hold_a: assert property (mctl_reg[p][MCTL_LOOP_BIT] |->
        (term_n_reg[p] && rts_n_reg[p]))
        else $error("modem outputs active during loopback");

      irq_set_a: assert property ((chg[p] && ier_reg[p][IER_MODEM_BIT]) |=>
        (istat_reg[p] [*2]) or (istat_reg[p] ##1 $past(clr[p])))
        else $error("port interrupt status not set by input change");
    end
  endgenerate

endmodule : umh_modem_hs
`default_nettype wire

// ---- verification/umh_modem_model.sv ----
// Modem partner: drives the eight handshake pins of both ports
`timescale 1ns/1ps
`default_nettype none
module umh_modem_model
(
  input wire logic i_core_clk,
  input wire logic [7:0] i_lvl_n,
  output logic [7:0] o_pin_n
);
  // Bits 3:0 port1, 7:4 port2, each clear, set-ready, ring, carrier
  initial o_pin_n = 8'hff;
  // Pins move only just after an edge, like a real line driver would
  always @(posedge i_core_clk)
  begin
    o_pin_n <= i_lvl_n;
  end
endmodule : umh_modem_model
`default_nettype wire

// ---- verification/tb_umh_modem_hs.sv ----
// Self-checking bench of the two-port modem handshake block
`timescale 1ns/1ps
`default_nettype none
module tb_umh_modem_hs;
  import umh_pkg::*;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [AXI_AW-1:0] awaddr, araddr, b;
  logic [AXI_DW-1:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp, dtr_n, rts_n, irqp;
  logic [7:0] lvl_n, pin_n;
  int err_count, samples_checked, cyc;

  umh_modem_model umh_modem_model_inst (.i_core_clk(clk), .i_lvl_n(lvl_n), .o_pin_n(pin_n));
  umh_modem_hs umh_modem_hs_inst (.i_core_clk(clk), .i_sys_rst(rst),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .i_clear_send_n_port1(pin_n[0]), .i_set_ready_n_port1(pin_n[1]),
    .i_ring_ind_n_port1(pin_n[2]), .i_carrier_det_n_port1(pin_n[3]),
    .i_clear_send_n_port2(pin_n[4]), .i_set_ready_n_port2(pin_n[5]),
    .i_ring_ind_n_port2(pin_n[6]), .i_carrier_det_n_port2(pin_n[7]),
    .o_term_ready_n_port1(dtr_n[0]), .o_term_ready_n_port2(dtr_n[1]),
    .o_req_send_n_port1(rts_n[0]), .o_req_send_n_port2(rts_n[1]),
    .o_irq_port1(irqp[0]), .o_irq_port2(irqp[1]), .o_irq(irq));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      summarize();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask : chk

  // Address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axr

  // Pin level change, then enough edges for synchroniser and interrupt
  task automatic pin(input int i, input logic v);
    lvl_n[i] <= v;
    repeat (8) @(posedge clk);
  endtask : pin

  initial
  begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h1;
    lvl_n = 8'hff;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("term_ready_rst", 32'h3, 32'(dtr_n));
    chk("req_send_rst", 32'h3, 32'(rts_n));
    for (int p = 0; p < 2; p++)
    begin
      b = 8'(p * 16);
      axr(b + OFF_MCTL);
      chk("mctl_rst", 32'h0, rd);
      axw(b + OFF_MCTL, 32'h03);
      chk("term_ready_on", 32'(2'h3 ^ (2'h1 << p)), 32'(dtr_n));
      chk("req_send_on", 32'(2'h3 ^ (2'h1 << p)), 32'(rts_n));
      axw(b + OFF_MCTL, 32'h13);
      chk("term_ready_loop", 32'h3, 32'(dtr_n));
      chk("req_send_loop", 32'h3, 32'(rts_n));
      axr(b + OFF_MCTL);
      chk("mctl_readback", 32'h13, rd);
      axw(b + OFF_MCTL, 32'h00);
      for (int i = 0; i < 4; i++)
      begin
        pin(p * 4 + i, 1'b0);
        axr(b + OFF_MSTAT);
        chk("mstat_level", 32'(1 << (i + 4)), rd);
        pin(p * 4 + i, 1'b1);
        axr(b + OFF_MSTAT);
        chk("mstat_rise", 32'(1 << i), rd);
        axr(b + OFF_MSTAT);
        chk("mstat_cleared", 32'h0, rd);
      end
      pin(p * 4 + 2, 1'b0);
      axr(OFF_ISTAT);
      chk("istat_masked", 32'h0, rd);
      pin(p * 4 + 2, 1'b1);
      axw(b + OFF_IER, 32'h08);
      axw(OFF_IEN, 32'(1 << p));
      pin(p * 4 + 3, 1'b0);
      chk("irq_port_dcd", 32'(1 << p), 32'(irqp));
      chk("irq_dcd", 32'h1, 32'(irq));
      axr(OFF_ISTAT);
      chk("istat_dcd", 32'(1 << p), rd);
      axw(OFF_ICLR, 32'(1 << p));
      chk("irq_port_clr", 32'h0, 32'(irqp));
      pin(p * 4 + 2, 1'b0);
      chk("irq_port_ri", 32'(1 << p), 32'(irqp));
      axw(OFF_IEN, 32'h0);
      chk("irq_masked", 32'h0, 32'(irq));
      axw(OFF_ICLR, 32'(1 << p));
      pin(p * 4 + 3, 1'b1);
      chk("irq_port_dcd_up", 32'(1 << p), 32'(irqp));
      axw(OFF_ICLR, 32'(1 << p));
      pin(p * 4 + 2, 1'b1);
      chk("irq_port_ri_up", 32'(1 << p), 32'(irqp));
      axw(OFF_ICLR, 32'(1 << p));
      // Clear-to-send and set-ready changes interrupt too
      for (int i = 0; i < 2; i++)
      begin
        pin(p * 4 + i, 1'b0);
        chk("irq_port_line", 32'(1 << p), 32'(irqp));
        axw(OFF_ICLR, 32'(1 << p));
        pin(p * 4 + i, 1'b1);
        chk("irq_port_line_up", 32'(1 << p), 32'(irqp));
        axw(OFF_ICLR, 32'(1 << p));
      end
      axw(b + OFF_IER, 32'h00);
      axr(b + OFF_MSTAT);
    end
    axw(8'h30, 32'h0);
    chk("unmapped_wr", 32'(RESP_SLVERR), 32'(resp));
    axr(8'h30);
    chk("unmapped_rd", 32'(RESP_SLVERR), 32'(resp));
    chk("unmapped_data", 32'h0, rd);
    summarize();
  end
endmodule : tb_umh_modem_hs
`default_nettype wire
